// file: hdl/dsl_pkg.sv
// Package for the serial DAC load and clear block.
// Assumes ref_clk at 100 MHz and a separate serial link clock.
package dsl_pkg;
   localparam int WORD_BITS = 16;
   localparam int CNT_BITS = 5;
   localparam logic [15:0] ZERO_CODE = 16'h0000;
   localparam logic [15:0] MID_CODE = 16'h8000;
   localparam logic [15:0] RESET_CODE = 16'h0000;
   localparam logic [4:0] FULL_COUNT = 5'h10;
   localparam int REF_CLK_MHZ = 100;
   localparam int POWERUP_US = 30;
   localparam int POWERUP_CYCLES = POWERUP_US * REF_CLK_MHZ;
   localparam int FIFO_DEPTH = 16;

   typedef struct packed {
      logic [15:0] code;
      logic full;
   } dsl_word_type;
endpackage : dsl_pkg

// file: hdl/dsl_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock domain and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dsl_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : dsl_fifo
`default_nettype wire

// file: hdl/dsl_dac_serial.sv
// Serial load and clear logic of a 16-bit voltage-output DAC.
// Assumes a host drives cs_n, sclk and din; async_clear_n and cs_n are pins.
`timescale 1ns/1ps
`default_nettype none
module dsl_dac_serial #(
   parameter bit BIPOLAR = 1'b0,
   parameter int POWERUP_CYCLES = dsl_pkg::POWERUP_CYCLES,
   parameter int FIFO_DEPTH = dsl_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic async_clear_n,
   output logic [15:0] dac_code,
   output logic frame_short,
   output logic ready_for_frame,
   output logic frame_dropped
);
   ////////////////////////////////////////////////////////////////////
   // Link domain: shift register on sclk
   // No reset reaches the link side; power-up values keep all but held_word and held_full out of X
   logic [15:0] shift_reg = 16'h0000;
   logic [4:0] bit_count = 5'h00;
   logic [15:0] held_word;
   logic held_full;
   logic frame_toggle = 1'b0;
   logic seen_toggle = 1'b1;

   // Shift with cs low; MSB first, newest bit at bit 0
   always_ff @(posedge sclk) begin
      if (!cs_n) begin
         shift_reg <= {shift_reg[14:0], din};
      end
   end

   // Count bits per frame; sclk stops between frames, so a new frame
   // is seen as frame_toggle differing from the copy taken last frame
   always_ff @(posedge sclk) begin
      if (!cs_n) begin
         seen_toggle <= frame_toggle;
         if (seen_toggle != frame_toggle) begin
            bit_count <= 5'h01;
         end else if (bit_count != dsl_pkg::FULL_COUNT) begin
            bit_count <= bit_count + 5'h01;
         end
      end
   end

   // Cs rise closes the frame; sclk may stop, so capture on cs edge
   always_ff @(posedge cs_n) begin
      held_word <= shift_reg;
      held_full <= (bit_count == dsl_pkg::FULL_COUNT) && (seen_toggle == frame_toggle);
      frame_toggle <= ~frame_toggle;
   end

   ////////////////////////////////////////////////////////////////////
   // Crossing into ref_clk: toggle event, held word stable meanwhile
   logic tog_1;
   logic tog_2;
   logic tog_3;
   logic clr_1;
   logic clr_2;
   logic frame_event;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         tog_1 <= 1'b0;
         tog_2 <= 1'b0;
         tog_3 <= 1'b0;
         clr_1 <= 1'b1;
         clr_2 <= 1'b1;
      end else begin
         tog_1 <= frame_toggle;
         tog_2 <= tog_1;
         tog_3 <= tog_2;
         clr_1 <= async_clear_n;
         clr_2 <= clr_1;
      end
   end

   assign frame_event = tog_2 ^ tog_3;

   ////////////////////////////////////////////////////////////////////
   // Word buffer between frame capture and DAC latch
   dsl_pkg::dsl_word_type fifo_in;
   dsl_pkg::dsl_word_type fifo_out;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;

   assign fifo_in.code = held_word;
   assign fifo_in.full = held_full;
   assign fifo_pop = fifo_out_valid;

   dsl_fifo #(
      .WIDTH($bits(dsl_pkg::dsl_word_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .srst(srst),
      .in_valid(frame_event),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out)
   );

   ////////////////////////////////////////////////////////////////////
   // DAC latch with clear
   logic [15:0] clear_code;
   assign clear_code = BIPOLAR ? dsl_pkg::MID_CODE : dsl_pkg::ZERO_CODE;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dac_code <= clear_code;
      end else if (!clr_2) begin
         dac_code <= clear_code;
      end else if (fifo_pop) begin
         dac_code <= fifo_out.code;
      end
   end

   // Short frame flag: last load had fewer than 16 edges
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         frame_short <= 1'b0;
      end else if (clr_2 && fifo_pop) begin
         frame_short <= !fifo_out.full;
      end
   end

   // Lost frame when buffer is full; cannot stall the host
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         frame_dropped <= 1'b0;
      end else if (frame_event && !fifo_in_ready) begin
         frame_dropped <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Power-up wait indication for the host
   logic [$clog2(POWERUP_CYCLES+1)-1:0] pu_count;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pu_count <= '0;
         ready_for_frame <= 1'b0;
      end else if (pu_count != ($clog2(POWERUP_CYCLES+1))'(POWERUP_CYCLES)) begin
         pu_count <= pu_count + 1'b1;
      end else begin
         ready_for_frame <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   property p_clear_holds;
      @(posedge ref_clk) disable iff (srst)
      !clr_2 |=> (dac_code == clear_code);
   endproperty
   a_clear_holds: assert property (p_clear_holds) else $error("clear not applied");

   property p_mid_clear;
      @(posedge ref_clk) disable iff (srst)
      (BIPOLAR && !clr_2) |=> (dac_code == 16'h8000);
   endproperty
   a_mid_clear: assert property (p_mid_clear) else $error("midscale clear wrong");

   property p_clear_blocks_load;
      @(posedge ref_clk) disable iff (srst)
      (!clr_2 && fifo_pop) |=> (dac_code == clear_code);
   endproperty
   a_clear_blocks_load: assert property (p_clear_blocks_load) else $error("load during clear");

   property p_load;
      @(posedge ref_clk) disable iff (srst)
      (clr_2 && fifo_pop) |=> (dac_code == $past(fifo_out.code));
   endproperty
   a_load: assert property (p_load) else $error("word not loaded");

   property p_short;
      @(posedge ref_clk) disable iff (srst)
      (clr_2 && fifo_pop) |=> (frame_short == !$past(fifo_out.full));
   endproperty
   a_short: assert property (p_short) else $error("short flag wrong");

   sequence s_event_full;
      frame_event && fifo_in_ready;
   endsequence
   property p_event_reaches;
      @(posedge ref_clk) disable iff (srst)
      s_event_full |=> fifo_out_valid;
   endproperty
   a_event_reaches: assert property (p_event_reaches) else $error("frame lost");

   property p_shift;
      @(posedge sclk) !cs_n |=> (shift_reg[0] == $past(din));
   endproperty
   a_shift: assert property (p_shift) else $error("bit not shifted");

   property p_msb;
      @(posedge sclk) !cs_n |=> (shift_reg[15:1] == $past(shift_reg[14:0]));
   endproperty
   a_msb: assert property (p_msb) else $error("shift order wrong");

   property p_ready;
      @(posedge ref_clk) disable iff (srst)
      ready_for_frame |=> ready_for_frame;
   endproperty
   a_ready: assert property (p_ready) else $error("ready dropped");
endmodule : dsl_dac_serial
`default_nettype wire

// file: tb/dsl_host_model.sv
// Host-side serial master model for the DAC load logic.
// Assumes the bench calls send() at a falling ref_clk edge.
`timescale 1ns/1ps
`default_nettype none
module dsl_host_model (
   output var logic sclk,
   output var logic cs_n,
   output var logic din
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Sends w[n-1:0] MSB first; sclk idles low outside frames
   task automatic send(input logic [31:0] w, input int n);
      cs_n = 1'b0;
      #5;
      for (int i = n - 1; i >= 0; i--) begin
         din = w[i];
         #3;
         sclk = 1'b1;
         #3;
         sclk = 1'b0;
      end
      #5;
      cs_n = 1'b1;
      din = ~din; // Last bit inverted after cs rise, stale value hidden
   endtask : send
endmodule : dsl_host_model
`default_nettype wire

// file: tb/dsl_dac_serial_tb_top.sv
// Self-checking bench for the serial DAC load and clear block.
// Assumes the host model above; unipolar variant, short power-up count.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
   $display("mismatch %0t value differs", $time); end end
module dsl_dac_serial_tb_top;
   logic ref_clk, srst, async_clear_n, sclk, cs_n, din;
   logic [15:0] dac_code, last, w, prev;
   logic [15:0] q[$];
   logic frame_short, ready_for_frame, frame_dropped;
   int fails = 0, n_tests = 0, seed = 36693;
   dsl_host_model dsl_host_model_i (.sclk(sclk), .cs_n(cs_n), .din(din));
   dsl_dac_serial #(.BIPOLAR(1'b0), .POWERUP_CYCLES(20), .FIFO_DEPTH(16)) dsl_dac_serial_i (
      .ref_clk(ref_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din),
      .async_clear_n(async_clear_n), .dac_code(dac_code), .frame_short(frame_short),
      .ready_for_frame(ready_for_frame), .frame_dropped(frame_dropped));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Watcher: every change of dac_code pops the oldest note
   initial last = 16'h0000;
   always @(negedge ref_clk) begin
      if (!srst && dac_code !== last) begin
         last = dac_code;
         if (q.size() == 0) `CHK(1'b1, 1'b0)
         else `CHK(dac_code, q.pop_front())
      end
   end
   task automatic gap();
      repeat (10) @(negedge ref_clk);
   endtask : gap
   task automatic frame(input logic [15:0] v);
      q.push_back(v);
      dsl_host_model_i.send({16'h0000, v}, 16);
      prev = v;
      gap();
   endtask : frame
   task automatic conclude();
      $display("tests %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude
   initial begin
      int k;
      logic [19:0] l;
      srst = 1'b1;
      async_clear_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      srst = 1'b0;
      `CHK(ready_for_frame, 1'b0)
      for (k = 0; k < 100 && ready_for_frame !== 1'b1; k++) @(negedge ref_clk);
      `CHK(ready_for_frame, 1'b1)
      if (ready_for_frame !== 1'b1) conclude();
      dsl_host_model_i.send(32'h0000_0000, 16); // Settles link-side flops
      gap();
      prev = 16'h0000;
      for (k = 0; k < 6; k++) begin // Random 16-bit words, bit 0 flipped from the previous word
         w = $random(seed);
         w[0] = ~prev[0];
         frame(w);
      end
      $display("test words done");
      l = $random(seed);
      l[0] = ~prev[0];
      q.push_back(l[15:0]);
      dsl_host_model_i.send({12'h000, l}, 20);
      prev = l[15:0];
      gap();
      $display("test long frame done");
      w = {prev[7:0], ~prev[7:0]};
      q.push_back(w);
      dsl_host_model_i.send({24'h0000_00, ~prev[7:0]}, 8);
      prev = w;
      gap();
      `CHK(frame_short, 1'b1)
      frame(~prev);
      `CHK(frame_short, 1'b0)
      $display("test short frame done");
      async_clear_n = 1'b0;
      q.push_back(16'h0000);
      gap();
      dsl_host_model_i.send({16'h0000, ~prev}, 16);
      gap();
      `CHK(dac_code, 16'h0000)
      async_clear_n = 1'b1;
      gap();
      frame(16'h5A5A);
      $display("test clear done");
      for (k = 0; k < 50 && q.size() != 0; k++) @(negedge ref_clk);
      `CHK(q.size(), 0)
      `CHK(frame_dropped, 1'b0)
      conclude();
   end
endmodule : dsl_dac_serial_tb_top
`default_nettype wire
